/* File: hdl/wake_timer_pkg.sv */
// Constants, register map and field layout of the long duration wake timer.
// Assumes a 200 MHz sys_clk and a register port driven by the serial front end.
// Behaviour
// - 16-bit after-run target, read and write, used while in Normal mode.
// - Lower 16 bits of 24-bit wake target, read and write, for low-power mode.
// - Upper 8 wake target bits sit in bits 0-7; bits 15-8 read zero.
// - Count registers reset to zero; live count clears when a count starts.
// - Writing start one begins counting unless the function code is unused; zero leaves timer disabled; resets zero.
// - Base bit zero steps 1 s, one steps 128 us; resets to long.
// - View zero accesses wake target; view one reads live 24-bit value once stopped.
// - Function field bits 4-6 picks functions one to five; codes above unused.
// - For functions two and three, target bit picks low-power off or on.
package wake_timer_pkg;

  // Clock and step times
  localparam longint CLK_HZ = 200_000_000;
  localparam longint LONG_STEP_NS = 1_000_000_000;
  localparam longint SHORT_STEP_NS = 128_000;
  localparam longint NS_PER_S = 1_000_000_000;
  localparam longint LONG_STEP_CYC = LONG_STEP_NS * CLK_HZ / NS_PER_S;
  localparam longint SHORT_STEP_CYC = SHORT_STEP_NS * CLK_HZ / NS_PER_S;
  localparam int PRE_W = 28;

  // Register indices on the register port
  localparam logic [1:0] REG_AFTER_RUN = 2'h0;
  localparam logic [1:0] REG_WAKE_LOW = 2'h1;
  localparam logic [1:0] REG_WAKE_HIGH = 2'h2;
  localparam logic [1:0] REG_CONTROL = 2'h3;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Control field positions
  localparam int BUSY_BIT = 0;
  localparam int START_BIT = 1;
  localparam int BASE_BIT = 2;
  localparam int VIEW_BIT = 3;
  localparam int FUNC_LSB = 4;
  localparam int LP_BIT = 7;
  localparam int FUNC_W = 3;
  localparam int HIGH_W = 8;
  localparam int CNT_W = 24;

  // Function codes
  localparam logic [2:0] FUNC_TWO = 3'h1;
  localparam logic [2:0] FUNC_THREE = 3'h2;
  localparam logic [2:0] FUNC_LAST = 3'h4;

  // One-hot timer phases
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_COUNT = 2'b10
  } phase_e;

endpackage

/* File: hdl/step_if.sv */
// Interface between the timer core and its step generator.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface step_if;
  logic run;
  logic short_base;
  logic tick;

  modport timer (output run, output short_base, input tick);
  modport step (input run, input short_base, output tick);
endinterface

/* File: hdl/step_gen.sv */
// Step generator: one tick per count step of the selected base.
// Assumes run and short_base come from flops of the timer core.
`timescale 1ns/1ps
module step_gen
  import wake_timer_pkg::*;
#(
  parameter logic [PRE_W-1:0] LONG_CYC = PRE_W'(LONG_STEP_CYC),
  parameter logic [PRE_W-1:0] SHORT_CYC = PRE_W'(SHORT_STEP_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  step_if.step stp
);

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic tick;
    logic last_base;
    logic mixed;
  } step_s;

  step_s s_q;
  step_s s_d;
  logic [PRE_W-1:0] limit;

  // Step length follows the base bit
  assign limit = stp.short_base ? SHORT_CYC : LONG_CYC;

  // Prescaler, restarted whenever the timer is not running
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.last_base = stp.short_base;
    if (!stp.run) begin
      s_d.pre = '0;
    end else if (s_q.pre >= limit - PRE_W'(1)) begin
      s_d.pre = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.pre = s_q.pre + PRE_W'(1);
    end
    // A base change inside a step makes that one step a mix of both lengths
    s_d.mixed = stp.run && !s_d.tick && (s_q.mixed || (stp.short_base != s_q.last_base));
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stp.tick = s_q.tick;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  step_len_a: assert property (
    (stp.run && $stable(stp.run) && $stable(stp.short_base) && s_q.tick
      && !$past(s_q.mixed || (stp.short_base != s_q.last_base)))
      |-> ($past(s_q.pre) == limit - PRE_W'(1)))
    else $error("step length does not match base");

endmodule

/* File: hdl/wake_timer.sv */
// Long duration wake timer: target registers, control and the live count.
// Assumes a register port fed by the serial front end and normal_mode from
// the mode controller, both on sys_clk.
`timescale 1ns/1ps
module wake_timer
  import wake_timer_pkg::*;
#(
  parameter logic [PRE_W-1:0] LONG_CYC = PRE_W'(LONG_STEP_CYC),
  parameter logic [PRE_W-1:0] SHORT_CYC = PRE_W'(SHORT_STEP_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [1:0] reg_sel,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic normal_mode,
  output logic timer_busy,
  output logic timer_expired,
  output logic [FUNC_W-1:0] function_select,
  output logic low_power_off_state,
  output logic low_power_on_state
);

  typedef struct packed {
    logic [15:0] after_run_target;
    logic [15:0] wake_target_low;
    logic [HIGH_W-1:0] wake_target_high;
    logic lowpower_target_select;
    logic [FUNC_W-1:0] function_select;
    logic view_select;
    logic count_base_select;
    logic timer_start;
    logic timer_busy;
    phase_e phase;
    logic [CNT_W-1:0] count;
    logic [15:0] rdata;
    logic expired;
    logic lp_off;
    logic lp_on;
  } timer_s;

  timer_s s_q;
  timer_s s_d;
  step_if stp ();

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Control register image as software reads it
  function automatic logic [15:0] ctrl_word(input timer_s s);
    logic [15:0] w;
    w = REG_RESET;
    w[BUSY_BIT] = s.timer_busy;
    w[START_BIT] = s.timer_start;
    w[BASE_BIT] = s.count_base_select;
    w[VIEW_BIT] = s.view_select;
    w[FUNC_LSB +: FUNC_W] = s.function_select;
    w[LP_BIT] = s.lowpower_target_select;
    return w;
  endfunction

  // Live value is shown only when the view asks for it and the timer is stopped
  function automatic logic live_view(input timer_s s);
    return s.view_select && !s.timer_busy;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Step generator

  step_gen #(
    .LONG_CYC(LONG_CYC),
    .SHORT_CYC(SHORT_CYC)
  ) u_step (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .stp(stp)
  );

  assign stp.run = s_q.timer_busy;
  assign stp.short_base = s_q.count_base_select;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [CNT_W-1:0] target;
    logic [CNT_W-1:0] next_cnt;
    logic lp_func;
    target = '0;
    next_cnt = '0;
    lp_func = 1'b0;
    s_d = s_q;
    s_d.expired = 1'b0;
    s_d.lp_off = 1'b0;
    s_d.lp_on = 1'b0;

    // Target depends on the chip mode
    if (normal_mode) begin
      target = CNT_W'(s_q.after_run_target);
    end else begin
      target = {s_q.wake_target_high, s_q.wake_target_low};
    end
    next_cnt = s_q.count + CNT_W'(1);
    lp_func = (s_q.function_select == FUNC_TWO) || (s_q.function_select == FUNC_THREE);

    // Count steps; reaching the target stops the timer
    case (s_q.phase)
      PH_IDLE: begin
        s_d.timer_busy = 1'b0;
      end
      PH_COUNT: begin
        if (stp.tick) begin
          s_d.count = next_cnt;
          if (next_cnt >= target) begin
            s_d.phase = PH_IDLE;
            s_d.timer_busy = 1'b0;
            s_d.timer_start = 1'b0;
            s_d.expired = 1'b1;
            s_d.lp_off = lp_func && !s_q.lowpower_target_select;
            s_d.lp_on = lp_func && s_q.lowpower_target_select;
          end
        end
      end
      default: begin
        s_d.phase = PH_IDLE;
        s_d.timer_busy = 1'b0;
      end
    endcase

    // Register writes; a start write wins over a same-cycle expiry
    if (reg_wr_en) begin
      case (reg_sel)
        REG_AFTER_RUN: begin
          s_d.after_run_target = reg_wdata;
        end
        REG_WAKE_LOW: begin
          if (!s_q.view_select) begin
            s_d.wake_target_low = reg_wdata;
          end
        end
        REG_WAKE_HIGH: begin
          if (!s_q.view_select) begin
            s_d.wake_target_high = reg_wdata[HIGH_W-1:0];
          end
        end
        REG_CONTROL: begin
          s_d.lowpower_target_select = reg_wdata[LP_BIT];
          s_d.function_select = reg_wdata[FUNC_LSB +: FUNC_W];
          s_d.view_select = reg_wdata[VIEW_BIT];
          s_d.count_base_select = reg_wdata[BASE_BIT];
          s_d.timer_start = reg_wdata[START_BIT];
          // An expiry pulse of this same cycle still goes out; the write wins
          if (!reg_wdata[START_BIT]) begin
            s_d.phase = PH_IDLE;
            s_d.timer_busy = 1'b0;
          end else if (reg_wdata[FUNC_LSB +: FUNC_W] > FUNC_LAST) begin
            s_d.timer_start = 1'b0;
            s_d.phase = PH_IDLE;
            s_d.timer_busy = 1'b0;
          end else if (s_d.phase == PH_IDLE) begin
            s_d.phase = PH_COUNT;
            s_d.timer_busy = 1'b1;
            s_d.count = '0;
          end
        end
        default: begin
          s_d.rdata = s_q.rdata;
        end
      endcase
    end

    // Read data, captured on a read strobe
    if (reg_rd_en) begin
      case (reg_sel)
        REG_AFTER_RUN: s_d.rdata = s_q.after_run_target;
        REG_WAKE_LOW: begin
          s_d.rdata = live_view(s_q) ? s_q.count[15:0] : s_q.wake_target_low;
        end
        REG_WAKE_HIGH: begin
          s_d.rdata = REG_RESET;
          s_d.rdata[HIGH_W-1:0] = live_view(s_q) ? s_q.count[CNT_W-1:16]
                                                 : s_q.wake_target_high;
        end
        REG_CONTROL: s_d.rdata = ctrl_word(s_q);
        default: s_d.rdata = REG_RESET;
      endcase
    end
  end

  // State register, cleared by reset except phase, which loads PH_IDLE
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.phase <= PH_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops
  assign reg_rdata = s_q.rdata;
  assign timer_busy = s_q.timer_busy;
  assign timer_expired = s_q.expired;
  assign function_select = s_q.function_select;
  assign low_power_off_state = s_q.lp_off;
  assign low_power_on_state = s_q.lp_on;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  logic ctrl_wr;
  assign ctrl_wr = reg_wr_en && (reg_sel == REG_CONTROL);

  after_run_store_a: assert property (
    (reg_wr_en && reg_sel == REG_AFTER_RUN)
      |=> (s_q.after_run_target == $past(reg_wdata)))
    else $error("after-run target not stored");

  wake_low_store_a: assert property (
    (reg_wr_en && reg_sel == REG_WAKE_LOW && !s_q.view_select)
      |=> (s_q.wake_target_low == $past(reg_wdata)))
    else $error("wake target low not stored");

  wake_high_read_a: assert property (
    (reg_rd_en && reg_sel == REG_WAKE_HIGH && !s_q.view_select)
      |=> (reg_rdata == {8'h00, $past(s_q.wake_target_high)}))
    else $error("wake target high read wrong");

  count_clear_a: assert property (
    (ctrl_wr && reg_wdata[START_BIT] && !timer_busy
      && reg_wdata[FUNC_LSB +: FUNC_W] <= FUNC_LAST)
      |=> (s_q.count == 24'h000000) && timer_busy)
    else $error("count not cleared at start");

  stop_write_a: assert property (
    (ctrl_wr && !reg_wdata[START_BIT])
      |=> !timer_busy ##1 (!timer_busy || $past(ctrl_wr && reg_wdata[START_BIT])))
    else $error("timer runs after stop write");

  live_read_a: assert property (
    (reg_rd_en && reg_sel == REG_WAKE_LOW && s_q.view_select && !timer_busy)
      |=> (reg_rdata == $past(s_q.count[15:0])))
    else $error("live value not reported");

  unused_func_a: assert property (
    (ctrl_wr && reg_wdata[START_BIT] && reg_wdata[FUNC_LSB +: FUNC_W] > FUNC_LAST
      && !timer_busy)
      |=> !timer_busy)
    else $error("unused function started timer");

  lp_route_a: assert property (
    (low_power_on_state || low_power_off_state)
      |-> timer_expired
          && ($past(function_select) == FUNC_TWO || $past(function_select) == FUNC_THREE)
          && (low_power_on_state == $past(s_q.lowpower_target_select)))
    else $error("low-power request routed wrongly");

  busy_read_a: assert property (
    (reg_rd_en && reg_sel == REG_CONTROL) |=> (reg_rdata[BUSY_BIT] == $past(timer_busy)))
    else $error("busy bit misreported");

  ctrl_upper_a: assert property (
    (reg_rd_en && reg_sel == REG_CONTROL) |=> (reg_rdata[15:8] == 8'h00))
    else $error("control upper bits not zero");

  start_cov_c: cover property (ctrl_wr && reg_wdata[START_BIT] ##1 timer_busy);
  expire_cov_c: cover property (timer_expired);
  lp_on_cov_c: cover property (low_power_on_state);
  live_cov_c: cover property (reg_rd_en && s_q.view_select && !timer_busy && s_q.count != '0);

endmodule

/* File: verification/tb_wake_timer.sv */
// Self-checking bench for the long duration wake timer.
// Drives the register port directly at the falling edge of sys_clk; short step counts.
`timescale 1ns/1ps
module tb_wake_timer;
  import wake_timer_pkg::*;
  localparam int L = 20;
  localparam int S = 4;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] reg_sel = 2'h0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic normal_mode = 1'b0;
  logic timer_busy;
  logic timer_expired;
  logic [FUNC_W-1:0] function_select;
  logic low_power_off_state;
  logic low_power_on_state;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;

  wake_timer #(.LONG_CYC(PRE_W'(L)), .SHORT_CYC(PRE_W'(S))) i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_sel(reg_sel), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .normal_mode(normal_mode), .timer_busy(timer_busy), .timer_expired(timer_expired),
    .function_select(function_select), .low_power_off_state(low_power_off_state),
    .low_power_on_state(low_power_on_state)
  );

  // Clock, 5 ns period
  always #2.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and hang guard
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Cut the run short if a wait never ends
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register port tasks and comparisons
  task check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task check_span(input string name, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  // One write strobe, held across exactly one rising edge
  task wr(input logic [1:0] sel, input logic [15:0] data);
    @(negedge sys_clk);
    reg_sel = sel;
    reg_wdata = data;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
  endtask

  // One read strobe; data is registered at the read edge and sampled a cycle and a half later
  task rd(input logic [1:0] sel, input logic [15:0] exp, input string name);
    @(negedge sys_clk);
    reg_sel = sel;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    @(negedge sys_clk);
    check_val(name, exp, reg_rdata);
  endtask

  // Count falling edges until the expiry pulse shows
  task wait_exp(output int cnt);
    cnt = 0;
    while (timer_expired !== 1'b1 && cnt < 1000) begin
      @(negedge sys_clk);
      cnt++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    // Reset values of all four registers
    rd(REG_AFTER_RUN, 16'h0000, "after_run reset");
    rd(REG_WAKE_LOW, 16'h0000, "wake_low reset");
    rd(REG_WAKE_HIGH, 16'h0000, "wake_high reset");
    rd(REG_CONTROL, 16'h0000, "control reset");
    // Full-width targets, upper wake bits masked
    wr(REG_AFTER_RUN, 16'hA5C3);
    rd(REG_AFTER_RUN, 16'hA5C3, "after_run rw");
    wr(REG_WAKE_LOW, 16'h5A3C);
    rd(REG_WAKE_LOW, 16'h5A3C, "wake_low rw");
    wr(REG_WAKE_HIGH, 16'hFFFF);
    rd(REG_WAKE_HIGH, 16'h00FF, "wake_high rw");
    // Control: upper byte and busy ignore writes, no start
    wr(REG_CONTROL, 16'hFFF1);
    rd(REG_CONTROL, 16'h00F0, "control mask");
    // Unused function code refuses the start
    wr(REG_CONTROL, 16'h0052);
    rd(REG_CONTROL, 16'h0050, "unused code start");
    check_val("busy unused", 16'h0000, {15'h0, timer_busy});
    // Function two, long base, 24-bit wake target of 3 in low-power mode
    wr(REG_WAKE_LOW, 16'h0003);
    wr(REG_WAKE_HIGH, 16'h0000);
    wr(REG_CONTROL, 16'h0012);
    check_val("busy start", 16'h0001, {15'h0, timer_busy});
    rd(REG_CONTROL, 16'h0013, "control busy");
    wait_exp(n);
    check_span("long run", 3 * L - 4, 3 * L + 4, n + 4);
    check_val("lp off", 16'h0001, {15'h0, low_power_off_state});
    check_val("lp on", 16'h0000, {15'h0, low_power_on_state});
    check_val("function", 16'h0001, {13'h0, function_select});
    @(negedge sys_clk);
    check_val("busy done", 16'h0000, {15'h0, timer_busy});
    // Live view once stopped differs from a new target, writes to it ignored
    wr(REG_WAKE_LOW, 16'h0007);
    wr(REG_WAKE_HIGH, 16'h0001);
    wr(REG_CONTROL, 16'h0018);
    rd(REG_WAKE_LOW, 16'h0003, "live low");
    rd(REG_WAKE_HIGH, 16'h0000, "live high");
    wr(REG_WAKE_LOW, 16'h1234);
    wr(REG_CONTROL, 16'h0010);
    rd(REG_WAKE_LOW, 16'h0007, "target kept");
    rd(REG_WAKE_HIGH, 16'h0001, "target high kept");
    // Function three, short base, after-run target 5 in Normal mode
    normal_mode = 1'b1;
    wr(REG_AFTER_RUN, 16'h0005);
    wr(REG_CONTROL, 16'h00A6);
    wait_exp(n);
    check_span("short run", 5 * S - 4, 5 * S + 4, n);
    check_val("lp on", 16'h0001, {15'h0, low_power_on_state});
    check_val("lp off", 16'h0000, {15'h0, low_power_off_state});
    // Stop in mid-count by writing start zero
    wr(REG_CONTROL, 16'h0002);
    repeat (5) @(negedge sys_clk);
    check_val("busy run", 16'h0001, {15'h0, timer_busy});
    wr(REG_CONTROL, 16'h0000);
    check_val("busy stop", 16'h0000, {15'h0, timer_busy});
    rd(REG_CONTROL, 16'h0000, "control stop");
    // The start cleared the live count left at 5 by the run before
    wr(REG_CONTROL, 16'h0008);
    rd(REG_WAKE_LOW, 16'h0000, "live cleared");
    // Each used function code, 0 to 4, reaches the function output
    for (int f = 0; f < 5; f++) begin
      wr(REG_CONTROL, 16'(f << FUNC_LSB));
      @(negedge sys_clk);
      check_val("function code", 16'(f), {13'h0, function_select});
    end
    test_done();
  end
endmodule
